// [rtl/icc_pkg.sv]
// package for the input capture channel: register map, fields, modes, carriers
package icc_pkg;
  // register addresses
  localparam logic [15:0] ADDR_FIFO = 16'h0140;
  localparam logic [15:0] ADDR_CTRL = 16'h0142;
  localparam logic [15:0] ADDR_IRQ = 16'h0144;
  // capture_control field positions
  localparam int MODE_LSB = 0;
  localparam int OVF_BIT = 4;
  localparam int NE_BIT = 3;
  localparam int EPI_LSB = 5;
  localparam int TSEL_BIT = 7;
  localparam int SIDL_BIT = 13;
  // interrupt flag/enable register fields
  localparam int IRQF_BIT = 0;
  localparam int IRQE_BIT = 1;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // fifo geometry
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 16;
  // prescale counts
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;
  // capture mode encodings
  typedef enum logic [2:0] {
    ICC_OFF = 3'b000,
    ICC_EVERY_EDGE = 3'b001,
    ICC_FALL = 3'b010,
    ICC_RISE = 3'b011,
    ICC_RISE4 = 3'b100,
    ICC_RISE16 = 3'b101,
    ICC_RSVD = 3'b110,
    ICC_RISE_IRQ = 3'b111
  } icc_mode_t;
  // register bus request carrier
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } icc_bus_req_t;
  // power state carrier
  typedef struct packed {
    logic sleep;
    logic idle;
  } icc_power_t;
endpackage

// [rtl/icc_capture.sv]
// single-channel input capture unit with four-word fifo and register port
//
// Notes on behaviour
// - modes: fall, rise, rise/4, rise/16, both edges
// - prescaler cleared when off or reset
// - four-entry sixteen-bit capture fifo
// - not-empty flag set until fifo drained
// - read returns oldest, remaining entries shift
// - fifth capture sets overflow, value dropped
// - after overflow ignore captures until drained
// - control bit 7 picks timer, timer3 default
// - every-edge mode: irq each edge, no overflow
// - mode 111 with enable wakes sleep/idle
// - sleep: rising-edge irq only under 111
// - idle: full function if timer on, sidl zero
// - idle with 111: pin is interrupt only
// - irq after events_per_interrupt plus one captures
// - irq flag gated by enable bit
// - fifo at 0140, control at 0142 reset zero
// - one channel only, the first
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module icc_capture #(
  parameter int DEPTH = icc_pkg::FIFO_DEPTH,
  parameter int WIDTH = icc_pkg::FIFO_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // timer interface
  input wire logic [WIDTH-1:0] timer2_count,
  input wire logic [WIDTH-1:0] timer3_count,
  input wire logic timer2_enabled,
  input wire logic timer3_enabled,
  // power state
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  // capture pin
  input wire logic capture_input_pin,
  // interrupt and wake
  output logic capture_irq,
  output logic wake_req
);

  // address match for one register of the map
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] target);
    return a == target;
  endfunction

  // true for the divided rising-edge modes
  function automatic logic is_prescaled(input icc_pkg::icc_mode_t m);
    return (m == icc_pkg::ICC_RISE4) || (m == icc_pkg::ICC_RISE16);
  endfunction

  // last prescaler count before a divided capture fires
  function automatic logic [3:0] prescale_last(input icc_pkg::icc_mode_t m);
    return (m == icc_pkg::ICC_RISE4) ? icc_pkg::PRE4_LAST : icc_pkg::PRE16_LAST;
  endfunction

  // control register image as software reads it
  function automatic logic [15:0] ctrl_image(input logic [2:0] mode_f, input logic not_empty,
                                             input logic ovf, input logic [1:0] epi,
                                             input logic tsel, input logic sidl);
    logic [15:0] img;
    img = 16'h0000;
    img[icc_pkg::MODE_LSB +: 3] = mode_f;
    img[icc_pkg::NE_BIT] = not_empty;
    img[icc_pkg::OVF_BIT] = ovf;
    img[icc_pkg::EPI_LSB +: 2] = epi;
    img[icc_pkg::TSEL_BIT] = tsel;
    img[icc_pkg::SIDL_BIT] = sidl;
    return img;
  endfunction

  // interrupt flag and enable register image
  function automatic logic [15:0] irq_image(input logic flag, input logic en);
    logic [15:0] img;
    img = 16'h0000;
    img[icc_pkg::IRQF_BIT] = flag;
    img[icc_pkg::IRQE_BIT] = en;
    return img;
  endfunction

  // reset release through two flops
  logic rst_s1_q, rst_s2_q, rst_n;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // bus request bundle
  icc_pkg::icc_bus_req_t req;
  icc_pkg::icc_power_t pwr;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign pwr = '{sleep: cpu_sleep, idle: cpu_idle};

  // control register fields
  logic [2:0] capture_mode_field_q;
  logic [1:0] events_per_interrupt_q;
  logic timebase_select_q;
  logic stop_in_idle_q;
  logic capture_irq_flag_q;
  logic capture_irq_enable_q;
  logic capture_overflow_flag_q;
  icc_pkg::icc_mode_t mode;
  assign mode = icc_pkg::icc_mode_t'(capture_mode_field_q);

  // pin synchroniser and edge detect
  logic pin_s1_q, pin_s2_q, pin_prev_q;
  logic rise, fall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= capture_input_pin;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  assign rise = pin_s2_q && !pin_prev_q;
  assign fall = !pin_s2_q && pin_prev_q;

  // selected timer running, needed for idle operation
  logic timer_on;
  assign timer_on = timebase_select_q ? timer2_enabled : timer3_enabled;

  // idle stops the channel unless stop_in_idle is clear and the timer runs
  logic idle_stopped;
  assign idle_stopped = pwr.idle && (stop_in_idle_q || !timer_on);

  // sleep, or idle under mode 111, leaves only the rising-edge interrupt
  logic irq_only;
  assign irq_only = pwr.sleep || (pwr.idle && mode == icc_pkg::ICC_RISE_IRQ);

  // captures run when awake, or idle with the channel still clocked
  logic full_func;
  assign full_func = !pwr.sleep && !idle_stopped;

  // either low-power state, for the wake request
  logic low_power;
  assign low_power = pwr.sleep || pwr.idle;

  // prescaler for the divided rising-edge modes
  logic [3:0] pre_cnt_q;
  logic [3:0] pre_last;
  logic pre_mode;
  assign pre_mode = is_prescaled(mode);
  assign pre_last = prescale_last(mode);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_q <= 4'h0;
    end else if (mode == icc_pkg::ICC_OFF || !pre_mode) begin
      pre_cnt_q <= 4'h0;
    end else if (rise && full_func) begin
      pre_cnt_q <= (pre_cnt_q == pre_last) ? 4'h0 : pre_cnt_q + 4'h1;
    end
  end

  // last input of a divided group: the one that is captured
  logic pre_hit;
  assign pre_hit = rise && pre_cnt_q == pre_last;

  // event decode per mode
  logic capt_event;
  always_comb begin
    capt_event = 1'b0;
    case (mode)
      icc_pkg::ICC_EVERY_EDGE: capt_event = rise || fall;
      icc_pkg::ICC_FALL: capt_event = fall;
      icc_pkg::ICC_RISE: capt_event = rise;
      icc_pkg::ICC_RISE4: capt_event = pre_hit;
      icc_pkg::ICC_RISE16: capt_event = pre_hit;
      icc_pkg::ICC_RISE_IRQ: capt_event = rise;
      default: capt_event = 1'b0;
    endcase
  end

  // fifo storage, oldest at slot 0
  logic [WIDTH-1:0] fifo_q [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] count_q;
  logic fifo_full, fifo_empty, push, pop, fifo_rd;
  logic [WIDTH-1:0] stamp;
  assign fifo_full = count_q == ($clog2(DEPTH+1))'(DEPTH);
  assign fifo_empty = count_q == '0;
  assign fifo_rd = req.rd && addr_hit(req.addr, icc_pkg::ADDR_FIFO);
  assign pop = fifo_rd && !fifo_empty;
  assign stamp = timebase_select_q ? timer2_count : timer3_count;

  // a capture that the channel may act on in its current power state
  logic capt_live;
  assign capt_live = capt_event && full_func && !irq_only;

  // overflow blocks capture until the fifo is empty again
  assign push = capt_live && !fifo_full && !capture_overflow_flag_q;

  // write slot: one lower when a read shifts the fifo in the same cycle
  logic [$clog2(DEPTH+1)-1:0] wr_slot;
  assign wr_slot = pop ? count_q - 1'b1 : count_q;

  // fifo data shifts forward on read
  always_ff @(posedge clk) begin
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        fifo_q[i] <= fifo_q[i + 1];
      end
    end
    if (push) begin
      fifo_q[wr_slot[$clog2(DEPTH)-1:0]] <= stamp;
    end
  end

  // occupancy moves only when exactly one of push and pop happens
  logic cnt_up, cnt_dn;
  assign cnt_up = push && !pop;
  assign cnt_dn = pop && !push;

  // fifo occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (cnt_up) begin
      count_q <= count_q + 1'b1;
    end else if (cnt_dn) begin
      count_q <= count_q - 1'b1;
    end
  end

  // fifth capture against a full fifo; every-edge mode never overflows
  logic ovf_event;
  assign ovf_event = capt_live && fifo_full && !pop && mode != icc_pkg::ICC_EVERY_EDGE;

  // overflow flag: set by a fifth capture, cleared once drained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_overflow_flag_q <= 1'b0;
    end else if (mode == icc_pkg::ICC_OFF) begin
      capture_overflow_flag_q <= 1'b0;
    end else if (ovf_event) begin
      capture_overflow_flag_q <= 1'b1;
    end else if (fifo_empty) begin
      capture_overflow_flag_q <= 1'b0;
    end
  end

  // interrupt event counter
  logic [1:0] irq_cnt_q;
  logic irq_event, count_done;
  assign count_done = irq_cnt_q == events_per_interrupt_q;
  always_comb begin
    irq_event = 1'b0;
    if (irq_only) begin
      irq_event = rise && mode == icc_pkg::ICC_RISE_IRQ;
    end else if (full_func && capt_event) begin
      if (mode == icc_pkg::ICC_EVERY_EDGE) begin
        irq_event = 1'b1;
      end else begin
        irq_event = (push || fifo_full) && count_done;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_cnt_q <= 2'h0;
    end else if (mode == icc_pkg::ICC_OFF || mode == icc_pkg::ICC_EVERY_EDGE) begin
      irq_cnt_q <= 2'h0;
    end else if (push && !irq_only) begin
      irq_cnt_q <= count_done ? 2'h0 : irq_cnt_q + 2'h1;
    end
  end

  // control register writes
  logic ctrl_wr, irq_wr;
  assign ctrl_wr = req.wr && addr_hit(req.addr, icc_pkg::ADDR_CTRL);
  assign irq_wr = req.wr && addr_hit(req.addr, icc_pkg::ADDR_IRQ);

  // capture mode field, zero after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_mode_field_q <= icc_pkg::CTRL_RST[icc_pkg::MODE_LSB +: 3];
    end else if (ctrl_wr) begin
      capture_mode_field_q <= req.wdata[icc_pkg::MODE_LSB +: 3];
    end
  end

  // events per interrupt field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      events_per_interrupt_q <= icc_pkg::CTRL_RST[icc_pkg::EPI_LSB +: 2];
    end else if (ctrl_wr) begin
      events_per_interrupt_q <= req.wdata[icc_pkg::EPI_LSB +: 2];
    end
  end

  // time base select, timer3 after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timebase_select_q <= icc_pkg::CTRL_RST[icc_pkg::TSEL_BIT];
    end else if (ctrl_wr) begin
      timebase_select_q <= req.wdata[icc_pkg::TSEL_BIT];
    end
  end

  // stop in idle bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_in_idle_q <= icc_pkg::CTRL_RST[icc_pkg::SIDL_BIT];
    end else if (ctrl_wr) begin
      stop_in_idle_q <= req.wdata[icc_pkg::SIDL_BIT];
    end
  end

  // interrupt flag: hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_irq_flag_q <= icc_pkg::IRQ_RST[icc_pkg::IRQF_BIT];
    end else if (irq_event) begin
      capture_irq_flag_q <= 1'b1;
    end else if (irq_wr) begin
      capture_irq_flag_q <= req.wdata[icc_pkg::IRQF_BIT];
    end
  end

  // interrupt enable, written by software only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_irq_enable_q <= icc_pkg::IRQ_RST[icc_pkg::IRQE_BIT];
    end else if (irq_wr) begin
      capture_irq_enable_q <= req.wdata[icc_pkg::IRQE_BIT];
    end
  end

  // interrupt and wake outputs
  assign capture_irq = capture_irq_flag_q && capture_irq_enable_q;
  assign wake_req = capture_irq_enable_q && low_power
                    && mode == icc_pkg::ICC_RISE_IRQ && capture_irq_flag_q;

  // read data select; empty fifo reads are undefined
  logic [15:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      case (req.addr)
        icc_pkg::ADDR_FIFO: rdata_d = fifo_q[0];
        icc_pkg::ADDR_CTRL: rdata_d = ctrl_image(capture_mode_field_q, !fifo_empty, capture_overflow_flag_q,
                                                 events_per_interrupt_q, timebase_select_q, stop_in_idle_q);
        icc_pkg::ADDR_IRQ: rdata_d = irq_image(capture_irq_flag_q, capture_irq_enable_q);
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // read data register, one cycle after the strobe, held until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q; // single channel only

endmodule

// [tb/icc_pin_model.sv]
// far-side pulse source driving the capture pin
`timescale 1ns/10ps
module icc_pin_model (
  // clock and command
  input wire logic clk,
  input wire logic go,
  // capture pin
  output logic pin
);
  logic [3:0] cnt_q = 4'h0;
  // one pulse per request: six cycles high, then six low
  always_ff @(posedge clk) begin
    if (go) begin
      cnt_q <= 4'hc;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign pin = cnt_q > 4'h6; // long enough for the synchroniser
endmodule

// [tb/icc_capture_chk.sv]
// assertions on the capture channel ports
`timescale 1ns/10ps
module icc_capture_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // power and outputs
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  input wire logic capture_irq,
  input wire logic wake_req
);
  logic [15:0] ctl_q;
  logic en_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow of the written control bits and interrupt enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= 16'h0000;
      en_q <= 1'b0;
    end else if (reg_wr && reg_addr == icc_pkg::ADDR_CTRL) begin
      ctl_q <= reg_wdata & 16'h20e7;
    end else if (reg_wr && reg_addr == icc_pkg::ADDR_IRQ) begin
      en_q <= reg_wdata[1];
    end
  end
  // a read request to one address
  sequence rd_of(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  reset_outputs_a: assert property ($rose(rst_b) |-> !capture_irq && !wake_req && reg_rdata == 16'h0000)
    else $error("outputs not quiet at reset release");
  ctrl_readback_a: assert property (rd_of(icc_pkg::ADDR_CTRL) |=> (reg_rdata & 16'h20e7) == ctl_q)
    else $error("control readback differs from write");
  enable_readback_a: assert property (rd_of(icc_pkg::ADDR_IRQ) |=> reg_rdata[1] == en_q)
    else $error("interrupt enable readback wrong");
  unmapped_zero_a: assert property (rd_of(16'h0146) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  irq_gate_a: assert property (capture_irq |-> en_q)
    else $error("interrupt passed while disabled");
  wake_power_a: assert property (wake_req |-> (cpu_sleep || cpu_idle) && capture_irq)
    else $error("wake outside low power or without interrupt");
  wake_mode_a: assert property (wake_req |-> ctl_q[2:0] == 3'b111)
    else $error("wake in a mode other than rise interrupt");
endmodule
bind icc_capture icc_capture_chk icc_capture_chk_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_sleep(cpu_sleep),
  .cpu_idle(cpu_idle), .capture_irq(capture_irq), .wake_req(wake_req));

// [tb/icc_capture_test.sv]
// testbench for the input capture channel
`timescale 1ns/10ps
module icc_capture_test;
  logic clk, rst_b, wr, rd, go, pin, irq, wake, slp, idl;
  logic [15:0] addr, wdata, rdata, t2, t3;
  int err_count, check_count;
  logic [2:0] md [4] = '{3'b100, 3'b101, 3'b010, 3'b001};
  int np [4] = '{4, 16, 1, 1};
  icc_capture icc_capture_i (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .timer2_count(t2), .timer3_count(t3), .timer2_enabled(1'b1),
    .timer3_enabled(1'b1), .cpu_sleep(slp), .cpu_idle(idl), .capture_input_pin(pin),
    .capture_irq(irq), .wake_req(wake));
  icc_pin_model icc_pin_model_i (.clk(clk), .go(go), .pin(pin));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare one value
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle register write
  task wr_reg(logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle register read, data checked in the following cycle
  task rd_reg(logic [15:0] a, logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", exp, rdata);
  endtask
  // pin pulses, timer3 holding base plus pulse index
  task pulses(int n, logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      t3 <= base + 16'(i);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (16) @(posedge clk);
    end
  endtask
  // verdict and end of run
  task give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst_b = 1'b0;
    {wr, rd, go, slp, idl} = 5'h00;
    {addr, wdata, t2, t3} = 64'h0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(icc_pkg::ADDR_CTRL, 16'h0000);
    rd_reg(icc_pkg::ADDR_IRQ, 16'h0000);
    rd_reg(16'h0146, 16'h0000);
    // overflow: fifth value lost, later events ignored until drained
    wr_reg(icc_pkg::ADDR_CTRL, 16'h0003);
    pulses(5, 16'h1000);
    rd_reg(icc_pkg::ADDR_CTRL, 16'h001b);
    pulses(1, 16'h1100);
    for (int i = 0; i < 4; i++) rd_reg(icc_pkg::ADDR_FIFO, 16'h1000 + 16'(i));
    rd_reg(icc_pkg::ADDR_CTRL, 16'h0003);
    // part-count the prescaler, switch off, then rise/4, rise/16, fall and every-edge modes
    wr_reg(icc_pkg::ADDR_CTRL, 16'h0004);
    pulses(2, 16'h0f00);
    wr_reg(icc_pkg::ADDR_CTRL, 16'h0000);
    foreach (md[k]) begin
      wr_reg(icc_pkg::ADDR_CTRL, {13'h0000, md[k]});
      pulses(np[k], 16'h2000);
      rd_reg(icc_pkg::ADDR_FIFO, 16'h2000 + 16'(np[k] - 1));
      if (md[k] == 3'b001) rd_reg(icc_pkg::ADDR_FIFO, 16'h2000);
      rd_reg(icc_pkg::ADDR_CTRL, {13'h0000, md[k]});
      wr_reg(icc_pkg::ADDR_CTRL, 16'h0000);
    end
    // timer2 as time base
    @(posedge clk);
    t2 <= 16'habcd;
    wr_reg(icc_pkg::ADDR_CTRL, 16'h0083);
    pulses(1, 16'h3000);
    rd_reg(icc_pkg::ADDR_FIFO, 16'habcd);
    // interrupt every second capture, then masked
    wr_reg(icc_pkg::ADDR_IRQ, 16'h0002);
    wr_reg(icc_pkg::ADDR_CTRL, 16'h0023);
    pulses(1, 16'h4000);
    @(negedge clk);
    chk("irq", 16'h0000, {15'h0000, irq});
    pulses(1, 16'h4001);
    @(negedge clk);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr_reg(icc_pkg::ADDR_IRQ, 16'h0000);
    pulses(2, 16'h4002);
    rd_reg(icc_pkg::ADDR_IRQ, 16'h0001);
    chk("irq", 16'h0000, {15'h0000, irq});
    for (int i = 0; i < 4; i++) rd_reg(icc_pkg::ADDR_FIFO, 16'h4000 + 16'(i));
    // sleep: rising edge wakes, nothing stored
    wr_reg(icc_pkg::ADDR_IRQ, 16'h0002);
    wr_reg(icc_pkg::ADDR_CTRL, 16'h0007);
    slp <= 1'b1;
    pulses(1, 16'h5000);
    @(negedge clk);
    chk("wake", 16'h0001, {15'h0000, wake});
    rd_reg(icc_pkg::ADDR_CTRL, 16'h0007);
    // idle: stopped while stop_in_idle is set, full capture once it is clear
    @(posedge clk);
    slp <= 1'b0;
    idl <= 1'b1;
    wr_reg(icc_pkg::ADDR_CTRL, 16'h2003);
    pulses(1, 16'h6000);
    rd_reg(icc_pkg::ADDR_CTRL, 16'h2003);
    wr_reg(icc_pkg::ADDR_CTRL, 16'h0003);
    pulses(1, 16'h6001);
    rd_reg(icc_pkg::ADDR_FIFO, 16'h6001);
    @(posedge clk);
    idl <= 1'b0;
    give_verdict();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule
